// [verilog/cfm_pkg.sv]
`default_nettype none
package cfm_pkg;
  // apb byte addresses
  localparam logic [11:0] ADDR_CMD    = 12'h000;
  localparam logic [11:0] ADDR_RESP   = 12'h004;
  localparam logic [11:0] ADDR_STAT   = 12'h008;
  localparam logic [11:0] ADDR_CLIENT = 12'h00c;
  // command codes
  localparam logic [7:0] C_CFG     = 8'h04;
  localparam logic [7:0] C_UPD     = 8'h5b;
  localparam logic [7:0] C_CLAIM   = 8'h32;
  localparam logic [7:0] C_RELEASE = 8'h33;
  localparam logic [7:0] C_SEL     = 8'h34;
  localparam logic [7:0] C_READ    = 8'h3a;
  localparam logic [7:0] C_WRITE   = 8'h39;
  localparam logic [7:0] C_ERASE   = 8'h38;
  localparam logic [7:0] C_REGRD   = 8'h35;
  // response codes
  localparam logic [11:0] RC_OK      = 12'h000;
  localparam logic [11:0] RC_UNALIGN = 12'h001;
  localparam logic [11:0] RC_UNKNOWN = 12'h002;
  localparam logic [11:0] RC_PARAM   = 12'h004;
  localparam logic [11:0] RC_BUSY    = 12'h1ff;
  localparam logic [11:0] RC_ERROR   = 12'h3ff;
  // response lengths, error source codes, limits
  localparam logic [10:0] RL_CFG        = 11'h006;
  localparam logic [10:0] RL_UPD        = 11'h009;
  localparam logic [10:0] RL_ONE        = 11'h001;
  localparam logic [11:0] SRC_APP       = 12'h0acf;
  localparam logic [11:0] SRC_DEC       = 12'h0dcf;
  localparam logic [31:0] MAX_REG_BYTES = 32'h0000_0008;
  localparam logic [31:0] ERASE_WORDS   = 32'h0000_4000;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_ARGS  = 3'b001,
    ST_WDATA = 3'b010,
    ST_EXEC  = 3'b011,
    ST_RESP  = 3'b100
  } cfm_state_t;
  typedef enum logic [1:0] {
    FL_READ  = 2'b00,
    FL_WRITE = 2'b01,
    FL_ERASE = 2'b10,
    FL_REGRD = 2'b11
  } cfm_flop_t;
  typedef struct packed {
    logic [31:0] err_code;
    logic [31:0] version;
    logic [31:0] err_loc;
    logic [31:0] err_det;
  } cfm_cfg_stat_t;
  typedef struct packed {
    logic [63:0] cur_image;
    logic [63:0] fail_image;
    logic [31:0] state;
    logic [3:0]  dcmf_index;
    logic [1:0]  err_src;
    logic [7:0]  app_ver;
    logic [7:0]  dec_ver;
    logic [31:0] err_loc;
    logic [31:0] err_det;
  } cfm_upd_stat_t;
  typedef struct packed {
    logic        req;
    cfm_flop_t   op;
    logic [3:0]  sel;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [31:0] len;
  } cfm_flash_cmd_t;
endpackage : cfm_pkg
`default_nettype wire

// [verilog/cfm_mailbox.sv]
// The register offsets and register access over APB were decided locally.
`default_nettype none
module cfm_mailbox
  import cfm_pkg::*;
#(
  parameter logic [31:0] MAX_RD_WORDS = 32'd1024
) (
  input  wire logic           pclk,
  input  wire logic           presetn,
  input  wire logic           psel,
  input  wire logic           penable,
  input  wire logic           pwrite,
  input  wire logic [11:0]    paddr,
  input  wire logic [31:0]    pwdata,
  output var  logic [31:0]    prdata,
  output var  logic           pready,
  output var  logic           pslverr,
  input  wire logic           config_running,
  input  wire cfm_cfg_stat_t  cfg_stat,
  input  wire logic           status_out_n,
  input  wire logic           config_in_n,
  input  wire logic [2:0]     boot_select,
  input  wire logic [5:0]     soft_funcs,
  input  wire cfm_upd_stat_t  upd_stat,
  input  wire logic [1:0]     max_retry,
  input  wire logic           retry_pulse,
  input  wire logic           image_loaded,
  output var  cfm_flash_cmd_t flash_cmd,
  input  wire logic           flash_ack,
  input  wire logic [31:0]    flash_rdata
);
  cfm_state_t  state_q;
  logic [7:0]  code_q, len_q, argc_q;
  logic [3:0]  id_q, client_q, owner_id_q;
  logic        owner_v_q, hdr_sent_q, boot_got_q;
  logic [31:0] arg0_q, arg1_q, retry_q;
  logic [11:0] err_q, chk_err;
  logic [10:0] rlen_q, ridx_q, chk_rlen;
  logic [2:0]  boot_q;
  logic [31:0] stat_w, resp_val, rd_val, fl_addr, fl_wdata;
  cfm_flop_t   fl_op;
  logic        acc, cmd_ok, resp_ok, stat_rd, cli_ok, done;
  logic        fl_acc, fl_exec, is_owner, rd_data;

  function automatic logic [7:0] exp_len(input logic [7:0] c);
    unique case (c)
      C_CFG, C_UPD, C_CLAIM, C_RELEASE: exp_len = 8'd0;
      C_SEL:                            exp_len = 8'd1;
      C_READ, C_ERASE, C_REGRD:         exp_len = 8'd2;
      default:                          exp_len = 8'hff;
    endcase
  endfunction : exp_len

  function automatic logic [11:0] src_code(input logic [1:0] s);
    unique case (s)
      2'd1:    src_code = SRC_APP;
      2'd2:    src_code = SRC_DEC;
      default: src_code = 12'h000;
    endcase
  endfunction : src_code

  ////////////////////////////////////////////////////////////////////////////
  // apb decode
  assign acc      = psel & penable & ~pready;
  assign cmd_ok   = pwrite & (paddr == ADDR_CMD) & (state_q inside {ST_IDLE, ST_ARGS, ST_WDATA});
  assign resp_ok  = ~pwrite & (paddr == ADDR_RESP) & (state_q == ST_RESP);
  assign stat_rd  = ~pwrite & (paddr == ADDR_STAT);
  assign cli_ok   = (paddr == ADDR_CLIENT);
  assign is_owner = owner_v_q & (owner_id_q == client_q);
  assign rd_data  = hdr_sent_q & (code_q == C_READ || code_q == C_REGRD) & (err_q == RC_OK);
  // flash work that stalls the bus access
  assign fl_acc   = acc & ((cmd_ok & (state_q == ST_WDATA) & (chk_err == RC_OK)) | (resp_ok & rd_data));
  assign fl_exec  = (state_q == ST_EXEC) & (code_q == C_ERASE) & (chk_err == RC_OK);
  assign done     = acc & (~fl_acc | flash_ack);

  // command check on captured header and arguments
  always_comb begin
    chk_err  = RC_OK;
    chk_rlen = 11'd0;
    if (code_q == C_WRITE ? (len_q < 8'd2 || {24'd0, len_q - 8'd2} != arg1_q)
                          : (len_q != exp_len(code_q))) begin
      chk_err = (exp_len(code_q) == 8'hff && code_q != C_WRITE) ? RC_UNKNOWN : RC_PARAM;
    end else begin
      unique case (code_q)
        C_CFG:     chk_rlen = RL_CFG;
        C_UPD:     chk_rlen = RL_UPD;
        C_CLAIM: begin
          if (owner_v_q || config_running) chk_err = RC_BUSY;
          chk_rlen = RL_ONE;
        end
        C_RELEASE, C_SEL: begin
          if (!is_owner) chk_err = RC_BUSY;
          chk_rlen = RL_ONE;
        end
        C_READ: begin
          if (!is_owner || config_running) chk_err = RC_BUSY;
          else if (arg0_q[1:0] != 2'b00) chk_err = RC_UNALIGN;
          else if (arg1_q == 32'd0 || arg1_q > MAX_RD_WORDS) chk_err = RC_PARAM;
          chk_rlen = arg1_q[10:0];
        end
        C_WRITE: begin
          if (!is_owner) chk_err = RC_BUSY;
          else if (arg0_q[1:0] != 2'b00) chk_err = RC_ERROR;
        end
        C_ERASE: begin
          if (!is_owner) chk_err = RC_BUSY;
          else if (arg0_q[15:0] != 16'h0000) chk_err = RC_ERROR;
          else if (arg1_q == 32'd0 || arg1_q[13:0] != 14'd0) chk_err = RC_PARAM;
        end
        C_REGRD: begin
          if (!is_owner) chk_err = RC_BUSY;
          else if (arg1_q == 32'd0 || arg1_q > MAX_REG_BYTES) chk_err = RC_PARAM;
          chk_rlen = 11'(arg1_q[3:0] + 4'd3) >> 2;
        end
        default: chk_err = RC_UNKNOWN;
      endcase
      if (chk_err != RC_OK) chk_rlen = 11'd0;
    end
  end

  // status response words
  always_comb begin
    stat_w = 32'h0;
    if (code_q == C_CFG) begin
      unique case (ridx_q[3:0])
        4'd0:    stat_w = cfg_stat.err_code;
        4'd1:    stat_w = cfg_stat.version;
        4'd2:    stat_w = {status_out_n, config_in_n, 27'd0, boot_q};
        4'd3:    stat_w = {26'd0, soft_funcs};
        4'd4:    stat_w = cfg_stat.err_loc;
        4'd5:    stat_w = cfg_stat.err_det;
        default: stat_w = 32'h0;
      endcase
    end else if (code_q == C_UPD) begin
      unique case (ridx_q[3:0])
        4'd0:    stat_w = upd_stat.cur_image[63:32];
        4'd1:    stat_w = upd_stat.cur_image[31:0];
        4'd2:    stat_w = upd_stat.fail_image[63:32];
        4'd3:    stat_w = upd_stat.fail_image[31:0];
        4'd4:    stat_w = upd_stat.state;
        4'd5:    stat_w = {upd_stat.dcmf_index, src_code(upd_stat.err_src),
                           upd_stat.app_ver, upd_stat.dec_ver};
        4'd6:    stat_w = upd_stat.err_loc;
        4'd7:    stat_w = upd_stat.err_det;
        4'd8:    stat_w = retry_q;
        default: stat_w = 32'h0;
      endcase
    end
  end

  // register read data is zero padded past the byte count
  always_comb begin
    rd_val = flash_rdata;
    if (code_q == C_REGRD && ridx_q == rlen_q - 11'd1) begin
      unique case (arg1_q[1:0])
        2'd1:    rd_val = {24'd0, flash_rdata[7:0]};
        2'd2:    rd_val = {16'd0, flash_rdata[15:0]};
        2'd3:    rd_val = {8'd0, flash_rdata[23:0]};
        default: rd_val = flash_rdata;
      endcase
    end
    if (!hdr_sent_q) resp_val = {4'h0, id_q, rlen_q[7:0], 4'h0, err_q};
    else if (rd_data) resp_val = rd_val;
    else resp_val = stat_w;
  end

  // flash request fields by phase
  always_comb begin
    fl_op    = FL_READ;
    fl_addr  = arg0_q;
    fl_wdata = 32'h0;
    if (state_q == ST_WDATA) begin
      fl_op    = FL_WRITE;
      fl_wdata = pwdata;
    end else if (state_q == ST_EXEC) begin
      fl_op = FL_ERASE;
    end else if (code_q == C_REGRD) begin
      fl_op    = FL_REGRD;
      fl_addr  = {21'd0, ridx_q};
      fl_wdata = arg0_q;
    end else begin
      fl_addr = arg0_q + {19'd0, ridx_q, 2'b00};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= done;
      pslverr <= done & ~(cmd_ok | resp_ok | stat_rd | cli_ok);
      prdata  <= 32'h0;
      if (done & resp_ok) prdata <= resp_val;
      else if (done & stat_rd) prdata <= {19'd0, flash_cmd.req, owner_id_q, owner_v_q, client_q, state_q};
      else if (done & cli_ok & ~pwrite) prdata <= {28'd0, client_q};
    end
  end

  // client id register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) client_q <= 4'h0;
    else if (done & cli_ok & pwrite) client_q <= pwdata[3:0];
  end

  // command assembly and response sequencing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q    <= ST_IDLE;
      code_q     <= 8'h0;
      id_q       <= 4'h0;
      len_q      <= 8'h0;
      argc_q     <= 8'h0;
      arg0_q     <= 32'h0;
      arg1_q     <= 32'h0;
      err_q      <= RC_OK;
      rlen_q     <= 11'd0;
      ridx_q     <= 11'd0;
      hdr_sent_q <= 1'b0;
    end else begin
      unique case (state_q)
        ST_IDLE: if (done & cmd_ok) begin
          code_q  <= pwdata[7:0];
          id_q    <= pwdata[27:24];
          len_q   <= pwdata[23:16];
          argc_q  <= 8'h0;
          arg0_q  <= 32'h0;
          arg1_q  <= 32'h0;
          state_q <= (pwdata[23:16] == 8'h0) ? ST_EXEC : ST_ARGS;
        end
        ST_ARGS, ST_WDATA: if (done & cmd_ok) begin
          argc_q <= argc_q + 8'd1;
          if (state_q == ST_WDATA) arg0_q <= arg0_q + 32'h4;
          else if (argc_q == 8'd0) arg0_q <= pwdata;
          else if (argc_q == 8'd1) arg1_q <= pwdata;
          if (argc_q + 8'd1 == len_q) state_q <= ST_EXEC;
          else if (code_q == C_WRITE && argc_q == 8'd1) state_q <= ST_WDATA;
        end
        ST_EXEC: if (!fl_exec || flash_ack) begin
          err_q      <= chk_err;
          rlen_q     <= chk_rlen;
          ridx_q     <= 11'd0;
          hdr_sent_q <= 1'b0;
          state_q    <= ST_RESP;
        end
        ST_RESP: if (done & resp_ok) begin
          if (!hdr_sent_q) hdr_sent_q <= 1'b1;
          else ridx_q <= ridx_q + 11'd1;
          if (hdr_sent_q ? (ridx_q + 11'd1 == rlen_q) : (rlen_q == 11'd0)) state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // flash ownership
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      owner_v_q  <= 1'b0;
      owner_id_q <= 4'h0;
    end else if (state_q == ST_EXEC && chk_err == RC_OK) begin
      if (code_q == C_CLAIM) begin
        owner_v_q  <= 1'b1;
        owner_id_q <= client_q;
      end else if (code_q == C_RELEASE) begin
        owner_v_q <= 1'b0;
      end
    end
  end

  // flash request handshake and chip select
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_cmd <= '0;
    end else begin
      if (flash_ack) begin
        flash_cmd.req <= 1'b0;
      end else if ((fl_acc | fl_exec) & ~flash_cmd.req) begin
        flash_cmd.req   <= 1'b1;
        flash_cmd.op    <= fl_op;
        flash_cmd.addr  <= fl_addr;
        flash_cmd.wdata <= fl_wdata;
        flash_cmd.len   <= arg1_q;
      end
      if (state_q == ST_EXEC && code_q == C_SEL && chk_err == RC_OK)
        flash_cmd.sel <= arg0_q[31:28];
    end
  end

  // retry counter, a new image clears it and a simultaneous retry counts as its first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) retry_q <= 32'h0;
    else if (image_loaded) retry_q <= {31'd0, retry_pulse && max_retry > 2'd1};
    else if (retry_pulse && retry_q[1:0] + 2'd1 < max_retry && retry_q < 32'd3)
      retry_q <= retry_q + 32'd1;
  end

  // boot select caught once after reset release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_got_q <= 1'b0;
      boot_q     <= 3'b000;
    end else if (!boot_got_q) begin
      boot_got_q <= 1'b1;
      boot_q     <= boot_select;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_claim_busy;
    (state_q == ST_EXEC && code_q == C_CLAIM && len_q == 8'd0 && (owner_v_q || config_running))
      |=> (err_q == RC_BUSY && owner_v_q == $past(owner_v_q));
  endproperty
  a_claim_busy: assert property (p_claim_busy) else $error("claim not refused");
  property p_foreign;
    (state_q == ST_EXEC && code_q == C_SEL && len_q == 8'd1 && !is_owner) |=> (err_q == RC_BUSY);
  endproperty
  a_foreign: assert property (p_foreign) else $error("non owner not refused");
  property p_rd_unalign;
    (state_q == ST_EXEC && code_q == C_READ && len_q == 8'd2 && is_owner && !config_running
      && arg0_q[1:0] != 2'b00) |=> (err_q == RC_UNALIGN && rlen_q == 11'd0);
  endproperty
  a_rd_unalign: assert property (p_rd_unalign) else $error("unaligned read accepted");
  property p_wr_unalign;
    (state_q == ST_WDATA && arg0_q[1:0] != 2'b00) |-> !flash_cmd.req || flash_cmd.op != FL_WRITE;
  endproperty
  a_wr_unalign: assert property (p_wr_unalign) else $error("unaligned write issued");
  property p_erase_align;
    (flash_cmd.req && flash_cmd.op == FL_ERASE) |-> (flash_cmd.addr[15:0] == 16'h0000);
  endproperty
  a_erase_align: assert property (p_erase_align) else $error("misaligned erase issued");
  property p_upd_len;
    (state_q == ST_EXEC && code_q == C_UPD && len_q == 8'd0) |=> (rlen_q == 11'd9 && err_q == RC_OK);
  endproperty
  a_upd_len: assert property (p_upd_len) else $error("update status length wrong");
  property p_cfg_len;
    (state_q == ST_EXEC && code_q == C_CFG && len_q == 8'd0) |=> (rlen_q == 11'd6);
  endproperty
  a_cfg_len: assert property (p_cfg_len) else $error("config status length wrong");
  property p_id_echo;
    (done && resp_ok && !hdr_sent_q) |=> (pready && prdata[27:24] == id_q);
  endproperty
  a_id_echo: assert property (p_id_echo) else $error("header id not echoed");
  property p_retry;
    (retry_pulse && !image_loaded && retry_q == 32'd0 && max_retry > 2'd1) |=> (retry_q == 32'd1);
  endproperty
  a_retry: assert property (p_retry) else $error("retry not counted");
endmodule : cfm_mailbox
`default_nettype wire

// [tb/cfm_flash_model.sv]
`default_nettype none
module cfm_flash_model
  import cfm_pkg::*;
(
  input  wire logic           pclk,
  input  wire logic           presetn,
  input  wire cfm_flash_cmd_t flash_cmd,
  input  wire logic [3:0]     lag,
  output var  logic           flash_ack,
  output var  logic [31:0]    flash_rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [3:0] wait_q;

  ////////////////////////////////////////////////////////////////////////////////
  // answer each request after lag idle cycles, one-cycle ack
  // data line flips every cycle outside ack so a value taken one cycle after the ack does not match
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_q      <= 4'h0;
      flash_ack   <= 1'b0;
      flash_rdata <= 32'h0000_0000;
    end else if (flash_cmd.req && !flash_ack && wait_q >= lag) begin
      flash_ack   <= 1'b1;
      flash_rdata <= flash_cmd.addr ^ 32'h5a5a_0000;
      wait_q      <= 4'h0;
    end else begin
      flash_ack   <= 1'b0;
      flash_rdata <= ~flash_rdata;
      wait_q      <= (flash_cmd.req && !flash_ack) ? wait_q + 4'h1 : 4'h0;
    end
  end
endmodule : cfm_flash_model
`default_nettype wire

// [tb/cfm_mailbox_bench.sv]
`default_nettype none
module cfm_mailbox_bench;
  import cfm_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic           pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0]    paddr;
  logic [31:0]    pwdata, prdata, flash_rdata, w;
  logic           config_running, status_out_n, config_in_n, retry_pulse, image_loaded, flash_ack, e;
  logic [2:0]     boot_select;
  logic [5:0]     soft_funcs;
  logic [1:0]     max_retry;
  logic [3:0]     lag;
  cfm_cfg_stat_t  cfg_stat;
  cfm_upd_stat_t  upd_stat;
  cfm_flash_cmd_t flash_cmd, seen_cmd;
  int             miscompares, checks;

  cfm_mailbox DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .config_running(config_running), .cfg_stat(cfg_stat), .status_out_n(status_out_n),
    .config_in_n(config_in_n), .boot_select(boot_select), .soft_funcs(soft_funcs), .upd_stat(upd_stat),
    .max_retry(max_retry), .retry_pulse(retry_pulse), .image_loaded(image_loaded), .flash_cmd(flash_cmd),
    .flash_ack(flash_ack), .flash_rdata(flash_rdata));
  cfm_flash_model flash (.pclk(pclk), .presetn(presetn), .flash_cmd(flash_cmd), .lag(lag),
    .flash_ack(flash_ack), .flash_rdata(flash_rdata));

  ////////////////////////////////////////////////////////////////////////////////
  // clock and capture of the request the flash side finished
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk) if (flash_ack) seen_cmd <= flash_cmd;

  ////////////////////////////////////////////////////////////////////////////////
  // compare, apb access, command and response helpers
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic er);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // request stands until pready is seen at a rising edge, data taken at that edge
    do @(posedge pclk); while (pready !== 1'b1);
    r       = prdata;
    er      = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // send header plus the first n of three argument words
  task automatic go(input int n, input logic [31:0] h, input logic [31:0] a, input logic [31:0] b,
                    input logic [31:0] c);
    logic [31:0] q[3];
    q = '{a, b, c};
    apb(1'b1, ADDR_CMD, h, w, e);
    for (int i = 0; i < n; i++) apb(1'b1, ADDR_CMD, q[i], w, e);
  endtask : go
  task automatic rsp(input logic [3:0] id, input logic [7:0] rl, input logic [11:0] rc);
    // poll state until execution (flash erase) has finished
    do apb(1'b0, ADDR_STAT, 32'h0, w, e); while (w[2:0] !== ST_RESP);
    apb(1'b0, ADDR_RESP, 32'h0, w, e);
    chk("resp header", w, {4'h0, id, rl, 4'h0, rc});
  endtask : rsp
  task automatic pop(input string nm, input logic [31:0] exp);
    apb(1'b0, ADDR_RESP, 32'h0, w, e);
    chk(nm, w, exp);
  endtask : pop
  // update status: nine words, checks images, version, failing image and retry count
  task automatic upd(input logic [3:0] id, input logic [31:0] retries, input logic [11:0] src);
    go(0, {4'h0, id, 8'h00, 8'h00, C_UPD}, 0, 0, 0);
    rsp(id, 8'h09, RC_OK);
    pop("upd cur image hi", upd_stat.cur_image[63:32]);
    pop("upd cur image lo", upd_stat.cur_image[31:0]);
    pop("upd fail image hi", upd_stat.fail_image[63:32]);
    pop("upd fail image lo", upd_stat.fail_image[31:0]);
    pop("upd state", upd_stat.state);
    pop("upd version", {upd_stat.dcmf_index, src, upd_stat.app_ver, upd_stat.dec_ver});
    pop("upd err loc", upd_stat.err_loc);
    pop("upd err det", upd_stat.err_det);
    pop("upd retries", retries);
  endtask : upd
  task automatic test_done;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done

  initial begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    test_done;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {retry_pulse, image_loaded, status_out_n, config_in_n} = 4'b0010;
    config_running = 1'b1;
    boot_select    = 3'b101;
    soft_funcs     = 6'h29;
    max_retry      = 2'd3;
    lag            = 4'h1;
    cfg_stat = {32'hf001_d002, 32'h0000_0003, 32'h0000_1234, 32'h0000_5678};
    upd_stat = {64'h1, 64'h2, 32'h3, 4'h2, 2'd1, 8'h01, 8'h02, 32'haaaa_0001, 32'hbbbb_0002};
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ADDR_RESP, 32'h0, w, e);
    chk("empty resp refused", {31'h0, e}, 32'h1);
    boot_select <= 3'b010; // strap moves after reset, latched value must stay
    apb(1'b0, 12'h010, 32'h0, w, e);
    chk("unmapped refused", {31'h0, e}, 32'h1);
    go(0, 32'h0100_0004, 0, 0, 0);
    rsp(4'h1, 8'h06, RC_OK);
    pop("cfg err", cfg_stat.err_code);
    pop("cfg version", cfg_stat.version);
    pop("cfg pins", {status_out_n, config_in_n, 27'h0, 3'b101});
    pop("cfg soft", {26'h0, soft_funcs});
    pop("cfg err loc", cfg_stat.err_loc);
    pop("cfg err det", cfg_stat.err_det);
    $display("test config status done");
    @(posedge pclk) retry_pulse <= 1'b1;
    @(posedge pclk) retry_pulse <= 1'b0;
    upd(4'h2, 32'h1, SRC_APP);
    upd_stat.err_src <= 2'd2;
    repeat (3) begin
      @(posedge pclk) retry_pulse <= 1'b1;
      @(posedge pclk) retry_pulse <= 1'b0;
    end
    upd(4'h3, 32'h2, SRC_DEC);
    upd_stat.err_src <= 2'd0;
    @(posedge pclk) image_loaded <= 1'b1;
    @(posedge pclk) image_loaded <= 1'b0;
    upd(4'h4, 32'h0, 12'h000);
    go(0, {8'h05, 16'h0000, 8'h77}, 0, 0, 0);
    rsp(4'h5, 8'h00, RC_UNKNOWN);
    $display("test update status done");
    go(0, {8'h05, 16'h0000, C_CLAIM}, 0, 0, 0);
    rsp(4'h5, 8'h00, RC_BUSY);
    config_running <= 1'b0;
    go(0, {8'h06, 16'h0000, C_CLAIM}, 0, 0, 0);
    rsp(4'h6, 8'h01, RC_OK);
    pop("claim word", 32'h0);
    apb(1'b1, ADDR_CLIENT, 32'h1, w, e);
    go(0, {8'h07, 16'h0000, C_CLAIM}, 0, 0, 0);
    rsp(4'h7, 8'h00, RC_BUSY);
    go(1, {8'h03, 8'h01, 8'h00, C_SEL}, 32'h0000_0000, 0, 0);
    rsp(4'h3, 8'h00, RC_BUSY);
    apb(1'b1, ADDR_CLIENT, 32'h0, w, e);
    go(1, {8'h08, 8'h01, 8'h00, C_SEL}, 32'h1000_0000, 0, 0);
    rsp(4'h8, 8'h01, RC_OK);
    pop("select word", 32'h0);
    go(2, {8'h09, 8'h02, 8'h00, C_READ}, 32'h100, 32'h2, 0);
    rsp(4'h9, 8'h02, RC_OK);
    pop("read 0", 32'h100 ^ 32'h5a5a_0000);
    pop("read 1", 32'h104 ^ 32'h5a5a_0000);
    chk("read sel", {28'h0, seen_cmd.sel}, 32'h1);
    config_running <= 1'b1;
    go(2, {8'h04, 8'h02, 8'h00, C_READ}, 32'h100, 32'h1, 0);
    rsp(4'h4, 8'h00, RC_BUSY);
    config_running <= 1'b0;
    go(2, {8'h0a, 8'h02, 8'h00, C_READ}, 32'h102, 32'h1, 0);
    rsp(4'ha, 8'h00, RC_UNALIGN);
    go(3, {8'h0b, 8'h03, 8'h00, C_WRITE}, 32'h203, 32'h1, 32'h1111_2222);
    rsp(4'hb, 8'h00, RC_ERROR);
    lag <= 4'h6;
    go(3, {8'h0c, 8'h03, 8'h00, C_WRITE}, 32'h200, 32'h1, 32'hcafe_0001);
    rsp(4'hc, 8'h00, RC_OK);
    chk("write op", {30'h0, seen_cmd.op}, {30'h0, FL_WRITE});
    chk("write addr", seen_cmd.addr, 32'h200);
    chk("write data", seen_cmd.wdata, 32'hcafe_0001);
    go(2, {8'h0d, 8'h02, 8'h00, C_ERASE}, 32'h1_0000, ERASE_WORDS, 0);
    rsp(4'hd, 8'h00, RC_OK);
    chk("erase op", {30'h0, seen_cmd.op}, {30'h0, FL_ERASE});
    chk("erase addr", seen_cmd.addr, 32'h1_0000);
    chk("erase len", seen_cmd.len, ERASE_WORDS);
    go(2, {8'h0e, 8'h02, 8'h00, C_ERASE}, 32'h1_8000, ERASE_WORDS, 0);
    rsp(4'he, 8'h00, RC_ERROR);
    lag <= 4'h0;
    go(2, {8'h0f, 8'h02, 8'h00, C_REGRD}, 32'h05, MAX_REG_BYTES, 0);
    rsp(4'hf, 8'h02, RC_OK);
    pop("regread 0", 32'h5a5a_0000);
    pop("regread 1", 32'h5a5a_0001);
    chk("regread op", {30'h0, seen_cmd.op}, {30'h0, FL_REGRD});
    chk("regread opcode", seen_cmd.wdata, 32'h05);
    go(2, {8'h0e, 8'h02, 8'h00, C_REGRD}, 32'h05, 32'h5, 0);
    rsp(4'he, 8'h02, RC_OK);
    pop("regread pad 0", 32'h5a5a_0000);
    pop("regread pad 1", 32'h0000_0001);
    go(2, {8'h00, 8'h02, 8'h00, C_REGRD}, 32'h05, 32'h9, 0);
    rsp(4'h0, 8'h00, RC_PARAM);
    go(0, {8'h01, 16'h0000, C_RELEASE}, 0, 0, 0);
    rsp(4'h1, 8'h01, RC_OK);
    pop("release word", 32'h0);
    apb(1'b1, ADDR_CLIENT, 32'h1, w, e);
    go(0, {8'h02, 16'h0000, C_CLAIM}, 0, 0, 0);
    rsp(4'h2, 8'h01, RC_OK);
    pop("claim word", 32'h0);
    $display("test flash access done");
    test_done;
  end
endmodule : cfm_mailbox_bench
`default_nettype wire
